/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdcc_consts.svh"
module testbench
   import sdcc_pkg::*;
;
   // Bench-driven ports and observed outputs
   logic                                   pclk;
   logic                                   presetn;
   logic                                   psel;
   logic                                   penable;
   logic                                   pwrite;
   logic [11:0]                            paddr;
   logic [31:0]                            pwdata;
   logic [31:0]                            prdata;
   logic                                   pready;
   logic                                   pslverr;
   logic [`SDCC_NCH-1:0][`SDCC_FILT_W-1:0] filt_data;
   logic [`SDCC_NCH-1:0]                   chan_on;
   int                                     fail_count;
   int                                     comparisons;
   logic [31:0]                            q;
   logic                                   err;

   // Per-round filter input, channel setup and expected result word
   // Last round: one-LSB bipolar offset reads twice as large in unipolar
   localparam logic [23:0] fv_tab [4] = '{24'hffffff, 24'h800000, 24'h000000, 24'h800100};
   localparam logic [9:0] cfg_tab [4][3] = '{'{10'h002, 10'h00a, 10'h012}, '{10'h002, 10'h00a, 10'h012},
                                             '{10'h002, 10'h00a, 10'h012}, '{10'h022, 10'h002, 10'h012}};
   localparam logic [15:0] exp_tab [4][3] = '{'{16'hffff, 16'h7fff, 16'hffff}, '{16'h8000, 16'h0000, 16'h0000},
                                              '{16'h0000, 16'h8000, 16'h0000}, '{16'h0100, 16'h8001, 16'h0002}};

   sdcc_ctrl sdcc_ctrl_i (
      .pclk      (pclk),
      .presetn   (presetn),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .filt_data (filt_data),
      .chan_on   (chan_on)
   );

   // 250 MHz clock
   always #2 pclk = ~pclk;

   function automatic logic [11:0] cctl(input int n);
      return `SDCC_CCTL0_OFF + `SDCC_REG_STRIDE * 12'(n);
   endfunction : cctl

   function automatic logic [11:0] mem(input int n);
      return `SDCC_MEM0_OFF + `SDCC_REG_STRIDE * 12'(n);
   endfunction : mem

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No limit here; a dead slave is caught by the watchdog
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Read and compare the masked word
   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, q & m);
   endtask : rd_chk

   // Bounded wait for the masked channels to power down
   task automatic wait_idle(input logic [2:0] m);
      int n;
      n = 0;
      while ((chan_on & m) !== 3'h0 && n < 20000) begin
         @(posedge pclk);
         n++;
      end
      chk("chan_on idle", 32'h0, {29'h0, chan_on & m});
   endtask : wait_idle

   // Bounded poll of a channel's ready flag, about two frames at most
   task automatic wait_rdy(input int c);
      int n;
      n = 0;
      do begin
         apb(1'b0, cctl(c), 32'h0);
         n++;
      end while (q[6] !== 1'b1 && n < 4000);
   endtask : wait_rdy

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results

   // Watchdog, beyond the roughly 72k cycles the tests need
   initial begin
      repeat (95000) @(posedge pclk);
      fail_count++;
      results();
   end

   initial begin
      int n;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      filt_data = '0;
      fail_count = 0;
      comparisons = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;

      // Reset values and unmapped addresses
      chk("chan_on reset", 32'h0, {29'h0, chan_on});
      rd_chk("cctl0 reset", cctl(0), 32'hffffffff, 32'h00000300);
      rd_chk("status reset", `SDCC_STAT_OFF, 32'hffffffff, 32'h0);
      apb(1'b0, 12'h024, 32'h0);
      chk("unmapped read err", 32'h1, {31'h0, err});
      chk("unmapped read data", 32'h0, q);
      apb(1'b1, 12'h030, 32'hffffffff);
      chk("unmapped write err", 32'h1, {31'h0, err});
      $display("test reset_and_map done");

      // Single conversions in every output format, three channels at once
      for (int r = 0; r < 4; r++) begin
         filt_data <= {3{fv_tab[r]}};
         for (int c = 0; c < 3; c++)
            apb(1'b1, cctl(c), {22'h0, cfg_tab[r][c] | 10'h001});
         wait_idle(3'b111);
         for (int c = 0; c < 3; c++) begin
            rd_chk("cctl after single", cctl(c), 32'h000003c1, 32'h00000040);
            rd_chk("result word", mem(c), 32'h0000ffff, {16'h0, exp_tab[r][c]});
            rd_chk("ready after read", cctl(c), 32'h00000040, 32'h0);
         end
      end
      $display("test formats done");

      // Group: ch0 single, ch1 continuous, ch2 master
      apb(1'b1, cctl(2), 32'h00000004);
      rd_chk("last group bit", cctl(2), 32'h00000004, 32'h0);
      apb(1'b1, cctl(0), 32'h00000006);
      apb(1'b1, cctl(1), 32'h00000004);
      apb(1'b1, cctl(2), 32'h00000001);
      rd_chk("group started", `SDCC_STAT_OFF, 32'h7, 32'h7);
      wait_idle(3'b001);
      rd_chk("ch0 result ready", cctl(0), 32'h00000041, 32'h00000040);
      rd_chk("group running", `SDCC_STAT_OFF, 32'h7, 32'h6);
      apb(1'b1, cctl(1), 32'h00000004);
      rd_chk("member stopped alone", `SDCC_STAT_OFF, 32'h7, 32'h4);
      apb(1'b0, mem(2), 32'h0);
      apb(1'b1, cctl(1), 32'h00000005);
      rd_chk("member restarted", `SDCC_STAT_OFF, 32'h7, 32'h6);
      wait_rdy(2);
      rd_chk("member skips first frame", cctl(1), 32'h00000040, 32'h0);
      apb(1'b0, mem(2), 32'h0);
      wait_rdy(2);
      rd_chk("member in step", cctl(1), 32'h00000040, 32'h00000040);
      apb(1'b1, cctl(2), 32'h00000000);
      rd_chk("master stop", `SDCC_STAT_OFF, 32'h7, 32'h0);
      chk("chan_on after master stop", 32'h0, {29'h0, chan_on});
      $display("test group done");

      // Continuous channel left unread until overflow
      apb(1'b1, cctl(0), 32'h00000000);
      apb(1'b1, cctl(1), 32'h00000001);
      n = 0;
      do begin
         apb(1'b0, cctl(1), 32'h0);
         n++;
      end while (q[7] !== 1'b1 && n < 8000);
      chk("overflow flag", 32'h80, q & 32'h80);
      rd_chk("still converting", `SDCC_STAT_OFF, 32'h7, 32'h2);
      apb(1'b0, mem(1), 32'h0);
      rd_chk("overflow kept on read", cctl(1), 32'h00000081, 32'h00000081);
      apb(1'b1, cctl(1), 32'h00000000);
      rd_chk("stopped", `SDCC_STAT_OFF, 32'h7, 32'h0);
      rd_chk("flags cleared", cctl(1), 32'h000000c1, 32'h0);
      $display("test overflow done");
      results();
   end
endmodule : testbench
`default_nettype wire

/* design/sdcc_consts.svh */
`ifndef SDCC_CONSTS_SVH
`define SDCC_CONSTS_SVH

// Channel count and data widths
`define SDCC_NCH          3
`define SDCC_FILT_W       24
`define SDCC_RES_W        16

// Register byte offsets
`define SDCC_CCTL0_OFF    12'h000
`define SDCC_MEM0_OFF     12'h010
`define SDCC_STAT_OFF     12'h020
`define SDCC_REG_STRIDE   12'h004

// Channel control field positions
`define SDCC_RUN_BIT      0
`define SDCC_SNGL_BIT     1
`define SDCC_GRP_BIT      2
`define SDCC_TWOS_BIT     3
`define SDCC_UNI_BIT      4
`define SDCC_LSB_BIT      5
`define SDCC_RDY_BIT      6
`define SDCC_OVF_BIT      7
`define SDCC_OSR_LO       8
`define SDCC_OSR_HI       9

// Reset values
`define SDCC_CTL_RST      7'h00
`define SDCC_OSR_RST      2'h3

// Modulator rate and decimation timing
`define SDCC_CLK_MHZ      250
`define SDCC_FM_MHZ       1
`define SDCC_FM_DIV       (`SDCC_CLK_MHZ / `SDCC_FM_MHZ)
`define SDCC_OSR_BASE     10'h020
`endif

/* design/sdcc_ctrl.sv */
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdcc_consts.svh"
module sdcc_ctrl
   import sdcc_pkg::*;
(
   // Clock and reset
   input  wire logic                                    pclk,
   input  wire logic                                    presetn,
   // APB slave
   input  wire logic                                    psel,
   input  wire logic                                    penable,
   input  wire logic                                    pwrite,
   input  wire logic [11:0]                             paddr,
   input  wire logic [31:0]                             pwdata,
   output logic      [31:0]                             prdata,
   output logic                                         pready,
   output logic                                         pslverr,
   // Filter outputs, full 24-bit scale per channel
   input  wire logic [`SDCC_NCH-1:0][`SDCC_FILT_W-1:0]  filt_data,
   // Channel power and filter enables
   output logic      [`SDCC_NCH-1:0]                    chan_on
);
   localparam int NCH = `SDCC_NCH;

   sdcc_ctl_s                          ctl      [NCH];
   logic      [NCH-1:0]                run;
   logic      [NCH-1:0]                next_run;
   logic      [NCH-1:0]                rdy;
   logic      [NCH-1:0]                ovf;
   logic      [NCH-1:0]                armed;
   logic      [NCH-1:0]                frame_done;
   logic      [NCH-1:0]                conv;
   logic      [NCH-1:0]                m_start;
   logic      [NCH-1:0]                m_stop;
   logic      [NCH-1:0]                grp_eff;
   logic      [1:0]                    lead     [NCH];
   logic      [9:0]                    cnt      [NCH];
   logic      [7:0]                    div_cnt;
   logic                               fm_tick;
   sdcc_bus_e                          bus_st;
   logic      [`SDCC_FILT_W-1:0]       mem_q;
   logic      [31:0]                   next_rdata;
   logic                               next_err;

   // Address decode, shared by the run, flag, result read and read data logic below
   logic        acc_ph;
   logic        wr_ph;
   logic        rd_ph;
   logic        is_cctl;
   logic        is_mem;
   logic        is_stat;
   logic [11:0] rel_cctl;
   logic [11:0] rel_mem;
   logic [1:0]  sel_ch;
   assign acc_ph   = psel & penable & (bus_st == SDCC_WAIT);
   assign wr_ph    = acc_ph & pwrite;
   assign rd_ph    = acc_ph & ~pwrite;
   assign rel_cctl = paddr - `SDCC_CCTL0_OFF;
   assign rel_mem  = paddr - `SDCC_MEM0_OFF;
   assign is_cctl  = (paddr >= `SDCC_CCTL0_OFF) && (rel_cctl < 12'(NCH * 4)) && (paddr[1:0] == 2'h0);
   assign is_mem   = (paddr >= `SDCC_MEM0_OFF) && (rel_mem < 12'(NCH * 4)) && (paddr[1:0] == 2'h0);
   assign is_stat  = (paddr == `SDCC_STAT_OFF);
   assign sel_ch   = is_mem ? rel_mem[3:2] : rel_cctl[3:2];

   // Modulator rate enable from a divider; the filter runs at this rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= '0;
         fm_tick <= 1'b0;
      end else begin
         fm_tick <= (div_cnt == 8'(`SDCC_FM_DIV - 1));
         div_cnt <= (div_cnt == 8'(`SDCC_FM_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
      end
   end

   // Group leader of each channel, walking down from the last
   always_comb begin
      for (int i = NCH - 1; i >= 0; i--) begin
         grp_eff[i] = (i == NCH - 1) ? 1'b0 : ctl[i].group_with_next;
         lead[i]    = grp_eff[i] ? lead[(i + 1) % NCH] : 2'(i);
      end
   end

   // Per-channel run bit decisions
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic       own_wr;
      logic [9:0] period;
      logic       grouped;
      assign own_wr  = wr_ph & is_cctl & (sel_ch == 2'(i));
      assign grouped = (lead[i] != 2'(i));
      assign period  = `SDCC_OSR_BASE << ctl[i].osr_sel;
      assign m_start[i] = ~run[i] & next_run[i];
      assign m_stop[i]  = run[i] & ~next_run[i];

      // Leader frame end; grouped channels borrow their master's frame
      assign frame_done[i] = run[i] & fm_tick & (cnt[i] == period - 10'h001);
      assign conv[i] = run[i] & armed[i] & frame_done[lead[i]];

      // Software write last, so a clear always wins over auto-set
      always_comb begin
         next_run[i] = run[i];
         if (ctl[i].single_conversion_select && conv[i]) begin
            next_run[i] = 1'b0;
         end
         if (grouped && m_start[lead[i]]) begin
            next_run[i] = 1'b1;
         end
         if (grouped && m_stop[lead[i]]) begin
            next_run[i] = 1'b0;
         end
         if (own_wr) begin
            next_run[i] = pwdata[`SDCC_RUN_BIT];
         end
      end

      // Decimation counter, restarted whenever the channel stops
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt[i] <= '0;
         end else if (!next_run[i]) begin
            cnt[i] <= '0;
         end else if (fm_tick) begin
            cnt[i] <= (cnt[i] == period - 10'h001) ? 10'h000 : cnt[i] + 10'h001;
         end
      end

      // Grouped channels wait for a master frame edge before converting
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            armed[i] <= 1'b0;
         end else if (!next_run[i]) begin
            armed[i] <= 1'b0;
         end else if (!grouped || m_start[lead[i]] || frame_done[lead[i]]) begin
            armed[i] <= 1'b1;
         end
      end

      // Configuration register fields
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ctl[i] <= {`SDCC_OSR_RST, 5'h00};
         end else if (own_wr) begin
            ctl[i].osr_sel                  <= pwdata[`SDCC_OSR_HI:`SDCC_OSR_LO];
            ctl[i].low_bits_access          <= pwdata[`SDCC_LSB_BIT];
            ctl[i].unipolar_select          <= pwdata[`SDCC_UNI_BIT];
            ctl[i].twos_complement_select   <= pwdata[`SDCC_TWOS_BIT];
            ctl[i].group_with_next          <= (i == NCH - 1) ? 1'b0 : pwdata[`SDCC_GRP_BIT];
            ctl[i].single_conversion_select <= pwdata[`SDCC_SNGL_BIT];
         end
      end

      // Flags: hardware set beats software or read clear
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rdy[i] <= 1'b0;
            ovf[i] <= 1'b0;
         end else begin
            if (conv[i]) begin
               rdy[i] <= 1'b1;
            end else if ((rd_ph && is_mem && sel_ch == 2'(i)) || (own_wr && !pwdata[`SDCC_RDY_BIT])) begin
               rdy[i] <= 1'b0;
            end
            if (conv[i] && rdy[i]) begin
               ovf[i] <= 1'b1;
            end else if (own_wr && !pwdata[`SDCC_OVF_BIT]) begin
               ovf[i] <= 1'b0;
            end
         end
      end
   end

   // Run bits and channel power follow the same next value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run     <= '0;
         chan_on <= '0;
      end else begin
         run     <= next_run;
         chan_on <= next_run;
      end
   end

   // Result storage; the filter word is captured at each conversion end
   sdcc_result_mem u_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (conv),
      .wr_data (filt_data),
      .rd_addr (sel_ch),
      .rd_q    (mem_q)
   );

   // Result formatting; filter word is pre-scaled so codes ignore the ratio
   function automatic logic [15:0] fmt(input logic [23:0] f, input sdcc_ctl_s c);
      logic [15:0] r;
      r = f[23:8];
      if (c.low_bits_access) begin
         r = f[15:0];
      end else if (c.unipolar_select) begin
         r = f[23] ? {f[22:8], 1'b0} | {15'h0000, f[22:8] == 15'h7fff} : 16'h0000;
      end else if (c.twos_complement_select) begin
         r = {~f[23], f[22:8]};
      end
      return r;
   endfunction : fmt

   // Read data selection, ready one cycle after the access phase opens
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      if (is_cctl) begin
         next_rdata = {22'h000000, ctl[sel_ch].osr_sel, ovf[sel_ch], rdy[sel_ch],
                       ctl[sel_ch].low_bits_access, ctl[sel_ch].unipolar_select,
                       ctl[sel_ch].twos_complement_select, grp_eff[sel_ch],
                       ctl[sel_ch].single_conversion_select, run[sel_ch]};
      end else if (is_mem) begin
         next_rdata = {16'h0000, fmt(mem_q, ctl[sel_ch])};
      end else if (is_stat) begin
         next_rdata = {29'h00000000, chan_on};
      end else begin
         next_err = 1'b1;
      end
   end

   // APB slave: one wait state on every access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_st  <= SDCC_IDLE;
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         case (bus_st)
            SDCC_IDLE: begin
               pready  <= 1'b0;
               pslverr <= 1'b0;
               if (psel && !penable) begin
                  bus_st <= SDCC_WAIT;
               end
            end
            SDCC_WAIT: begin
               if (psel && penable) begin
                  bus_st  <= SDCC_DONE;
                  pready  <= 1'b1;
                  pslverr <= next_err;
                  prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
               end
            end
            SDCC_DONE: begin
               bus_st  <= SDCC_IDLE;
               pready  <= 1'b0;
               pslverr <= 1'b0;
            end
            default: begin
               bus_st <= SDCC_IDLE;
               pready <= 1'b0;
            end
         endcase
      end
   end

   // Checks kept beside the logic
   ready_on_result_a: assert property (@(posedge pclk) disable iff (!presetn)
      |conv |=> (rdy & $past(conv)) == $past(conv))
      else $error("ready flag not set by result");
   ready_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_ph && is_mem && !conv[sel_ch] |=> !rdy[$past(sel_ch)])
      else $error("ready flag survived result read");
   offset_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      fmt(24'h800000, 7'h00) == 16'h8000 && fmt(24'hffffff, 7'h00) == 16'hffff)
      else $error("offset binary code wrong");
   twos_fs_a: assert property (@(posedge pclk) disable iff (!presetn)
      fmt(24'hffffff, 7'h04) == 16'h7fff && fmt(24'h000000, 7'h04) == 16'h8000)
      else $error("twos complement code wrong");
   unipolar_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      fmt(24'h800000, 7'h08) == 16'h0000 && fmt(24'hffffff, 7'h08) == 16'hffff)
      else $error("unipolar code wrong");
   single_autoclr_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv[0] && ctl[0].single_conversion_select && !(wr_ph && is_cctl) |=> !run[0])
      else $error("single conversion run bit not cleared");
   last_grp_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctl[NCH-1].group_with_next)
      else $error("last channel group bit set");
   master_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      grp_eff[1] && m_stop[lead[1]] && !(wr_ph && is_cctl && sel_ch == 2'd1)
      |=> !run[1] && !chan_on[1])
      else $error("group member kept running after master stop");
   overflow_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv[1] && rdy[1] |=> ovf[1] [*2])
      else $error("overflow not flagged");
   powered_down_a: assert property (@(posedge pclk) disable iff (!presetn)
      !run[0] |-> cnt[0] == 10'h000 && !conv[0])
      else $error("stopped channel still converting");

   // Grouping and flag checks on the middle channel, last channel group bit read, low bit format on any channel
   group_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      grp_eff[1] && m_start[lead[1]] && !(wr_ph && is_cctl && sel_ch == 2'd1) |=> run[1] && chan_on[1])
      else $error("group member not started with master");
   member_align_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(run[1]) && $past(lead[1]) == 2'd2 && !$past(m_start[2]) && !$past(frame_done[2]) |-> !armed[1])
      else $error("late group member converted off master frame");
   member_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ph && is_cctl && sel_ch == 2'd1 && !pwdata[`SDCC_RUN_BIT] && run[2] && !conv[2] |=> !run[1] && run[2])
      else $error("member clear did not stop only that channel");
   continuous_run_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv[1] && !ctl[1].single_conversion_select && !(wr_ph && is_cctl && sel_ch == 2'd1) && !m_stop[lead[1]]
      |=> run[1])
      else $error("continuous channel stopped by itself");
   last_grp_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_ph && is_cctl && sel_ch == 2'd2 |=> !prdata[`SDCC_GRP_BIT])
      else $error("last channel group bit read as one");
   low_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_ph && is_mem && ctl[sel_ch].low_bits_access |=> prdata[15:0] == $past(mem_q[15:0]))
      else $error("low bit access returned wrong bits");
   sticky_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
      ovf[1] && !(wr_ph && is_cctl && sel_ch == 2'd1) |=> ovf[1])
      else $error("overflow flag cleared without software");
endmodule : sdcc_ctrl
`default_nettype wire

/* design/sdcc_pkg.sv */
package sdcc_pkg;
   // Per-channel configuration as written by software
   typedef struct packed {
      logic [1:0] osr_sel;
      logic       low_bits_access;
      logic       unipolar_select;
      logic       twos_complement_select;
      logic       group_with_next;
      logic       single_conversion_select;
   } sdcc_ctl_s;

   // Bus slave states, Gray along the transfer path
   typedef enum logic [1:0] {
      SDCC_IDLE = 2'b00,
      SDCC_WAIT = 2'b01,
      SDCC_DONE = 2'b11
   } sdcc_bus_e;
endpackage : sdcc_pkg

/* design/sdcc_result_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdcc_consts.svh"
module sdcc_result_mem (
   // Clock and reset
   input  wire logic                                     pclk,
   input  wire logic                                     presetn,
   // One write port per channel
   input  wire logic [`SDCC_NCH-1:0]                     wr_en,
   input  wire logic [`SDCC_NCH-1:0][`SDCC_FILT_W-1:0]   wr_data,
   // Registered read port
   input  wire logic [1:0]                               rd_addr,
   output logic      [`SDCC_FILT_W-1:0]                  rd_q
);
   logic [`SDCC_NCH-1:0][`SDCC_FILT_W-1:0] mem;

   // Grouped channels finish together, so every entry has its own port
   for (genvar i = 0; i < `SDCC_NCH; i++) begin : g_ent
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mem[i] <= '0;
         end else if (wr_en[i]) begin
            mem[i] <= wr_data[i];
         end
      end
   end

   // Read data leaves through a register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q <= '0;
      end else if (rd_addr < 2'(`SDCC_NCH)) begin
         rd_q <= mem[rd_addr];
      end else begin
         rd_q <= '0;
      end
   end
endmodule : sdcc_result_mem
`default_nettype wire
